// ==== core/seewp_mem.sv ====
// Simple dual-port byte memory with registered read data
`timescale 1ns/1ps
module seewp_mem #(
	parameter int AW = 13,
	parameter int DW = 8
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata_q
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_q <= mem[raddr];
	end
endmodule

// ==== core/seewp_target.sv ====
// Two-wire serial memory target: framing, addressing, page write and programming cycle
//
// Notes on behaviour
// - SDA sampled on SCL rise; our SDA changes only after SCL fall.
// - SDA is open drain: we only pull low or release.
// - Outside start and stop, SDA stays stable while SCL is high.
// - SDA falling with SCL high is a start; word reception begins.
// - SDA rising with SCL high is a stop; reads end in standby.
// - Stop after accepted write data starts programming; bus ignored until done.
// - Words are eight bits; ninth clock carries the receiver's low acknowledge.
// - Writes with inhibit low acknowledge every received byte.
// - Reads acknowledge the address word; controller ack gets next byte.
// - Controller no-ack then stop ends the read, back to standby.
// - No ack and no stop after read byte: stay released, send nothing.
// - First word: type code nibble, select A2 A1 A0, direction bit.
// - Respond only on type and strap match; otherwise no ack, standby.
// - Direction bit low writes, high reads, entered after our acknowledge.
// - Open straps read low; eight devices may share a bus.
// - Byte write: address word, two address bytes, one data byte, stop.
// - Page write takes up to 32 bytes, incrementing only page offset.
// - Page offset wraps inside the page, overwriting earlier buffered bytes.
// - Inhibit high: ack address bytes, no-ack first data, program nothing.
// - Inhibit low allows writes anywhere; reads ignore the inhibit pin.
// - Open inhibit pin reads low, so writes are allowed.
// - Programming lasts at most five milliseconds from the stop.
// - No ack to a write address word while programming; ack afterwards.
`timescale 1ns/1ps
module seewp_target
	import seewp_pkg::*;
#(
	// Arbitrary neutral type code; strap-independent part of the address word
	parameter logic [seewp_pkg::TYPE_CODE_W-1:0] TYPE_CODE = 4'h5,
	parameter int PROG_CYCLES_P = seewp_pkg::PROG_CYCLES,
	parameter int PAGE_BYTES_P = seewp_pkg::PAGE_BYTES
) (
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	input wire logic SCL,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE,
	input wire logic WRITE_INHIBIT,
	input wire logic SELECT_STRAP_BIT0,
	input wire logic SELECT_STRAP_BIT1,
	input wire logic SELECT_STRAP_BIT2,
	output logic PROG_BUSY
);
	import seewp_pkg::*;

	localparam int PCW = $clog2(PROG_CYCLES_P + 1);
	localparam logic [PCW-1:0] PROG_LAST = PCW'(PROG_CYCLES_P - 1);
	localparam logic [PCW-1:0] COPY_FIRST = PCW'(1);
	localparam logic [PCW-1:0] COPY_LAST = PCW'(PAGE_BYTES_P);

	function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
		input logic page_only);
		logic [ADDR_W-1:0] r;
		r = a + 13'h0001;
		if (page_only) begin
			r = {a[ADDR_W-1:PAGE_OFF_W], r[PAGE_OFF_W-1:0]};
		end
		return r;
	endfunction

	function automatic logic msb_first_bit(input logic [WORD_BITS-1:0] b,
		input logic [3:0] idx);
		return b[3'(LAST_DATA_BIT - idx)];
	endfunction

	// Link side: sampling and drive registers on the serial clock
	logic samp_bit_link_q;
	logic drv_link_q;
	// Written in the system domain below, read here at each fall
	logic drv_q, drv_d;

	always_ff @(posedge SCL) begin
		samp_bit_link_q <= SDA_I;
	end

	// drive after fall; system side holds drv_q steady across each fall
	always_ff @(negedge SCL) begin
		drv_link_q <= drv_q;
	end

	// Pin synchronisers
	logic scl_s1_q, scl_s2_q, scl_s3_q;
	logic sda_s1_q, sda_s2_q, sda_s3_q;
	logic wp_s1_q, wp_s2_q;
	logic [STRAP_W-1:0] strap_s1_q, strap_s2_q;

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_s3_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_s3_q <= 1'b1;
			wp_s1_q <= 1'b0;
			wp_s2_q <= 1'b0;
			strap_s1_q <= 3'h0;
			strap_s2_q <= 3'h0;
		end else begin
			scl_s1_q <= SCL;
			scl_s2_q <= scl_s1_q;
			scl_s3_q <= scl_s2_q;
			sda_s1_q <= SDA_I;
			sda_s2_q <= sda_s1_q;
			sda_s3_q <= sda_s2_q;
			wp_s1_q <= WRITE_INHIBIT;
			wp_s2_q <= wp_s1_q;
			strap_s1_q <= {SELECT_STRAP_BIT2, SELECT_STRAP_BIT1, SELECT_STRAP_BIT0};
			strap_s2_q <= strap_s1_q;
		end
	end

	logic start_ev, stop_ev, scl_rise, scl_fall, samp_bit;

	assign start_ev = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
	assign stop_ev = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;
	assign scl_rise = scl_s2_q && !scl_s3_q;
	assign scl_fall = !scl_s2_q && scl_s3_q;
	// The synchronised rise proves the link sample is settled
	assign samp_bit = samp_bit_link_q;

	// Protocol state
	seewp_state_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [WORD_BITS-1:0] sh_q, sh_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic ack_q, ack_d;
	logic [PAGE_BYTES-1:0] mask_q, mask_d;
	logic [PCW-1:0] prog_q, prog_d;
	logic armed_q, armed_d;

	logic [WORD_BITS-1:0] byte_in;
	logic addr_match;
	logic buf_we;
	logic arr_we;
	logic [PAGE_OFF_W-1:0] copy_idx;
	logic [PAGE_OFF_W-1:0] buf_raddr;
	logic [WORD_BITS-1:0] buf_rdata;
	logic [WORD_BITS-1:0] arr_rdata;

	assign byte_in = {sh_q[WORD_BITS-2:0], samp_bit};
	assign addr_match = (byte_in[WORD_BITS-1:TYPE_LSB] == TYPE_CODE) &&
		(byte_in[TYPE_LSB-1:STRAP_LSB] == strap_s2_q);
	assign copy_idx = PAGE_OFF_W'(prog_q - COPY_FIRST);
	assign buf_raddr = PAGE_OFF_W'(prog_q);

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		addr_d = addr_q;
		ack_d = ack_q;
		mask_d = mask_q;
		prog_d = prog_q;
		armed_d = armed_q | scl_fall;
		buf_we = 1'b0;
		arr_we = 1'b0;
		if (st_q == ST_PROG) begin
			// no acknowledge possible in this state
			prog_d = prog_q + COPY_FIRST;
			if (prog_q >= COPY_FIRST && prog_q <= COPY_LAST) begin
				arr_we = mask_q[copy_idx];
			end
			if (prog_q == PROG_LAST) begin
				// back in standby, polls are answered again
				st_d = ST_IDLE;
				mask_d = MASK_RST;
			end
		end else if (stop_ev) begin
			cnt_d = 4'h0;
			ack_d = 1'b0;
			prog_d = '0;
			// stop after read goes to standby
			// inhibit raised mid-write still programs nothing
			if (st_q == ST_WDATA && |mask_q && !wp_s2_q) begin
				st_d = ST_PROG;
			end else begin
				st_d = ST_IDLE;
			end
		end else if (start_ev) begin
			st_d = ST_DEV;
			cnt_d = 4'h0;
			ack_d = 1'b0;
		end else if (scl_rise && st_q != ST_IDLE && st_q != ST_WAIT) begin
			if (cnt_q != ACK_SLOT) begin
				sh_d = byte_in;
				cnt_d = cnt_q + 4'h1;
				if (cnt_q == LAST_DATA_BIT) begin
					unique case (st_q)
						ST_DEV: begin
							if (addr_match) begin
								ack_d = 1'b1;
							end else begin
								st_d = ST_IDLE;
							end
						end
						ST_ADDR_HI: begin
							// high byte first, upper bits dropped
							ack_d = 1'b1;
							addr_d[ADDR_W-1:WORD_BITS] = byte_in[ADDR_HI_W-1:0];
						end
						ST_ADDR_LO: begin
							ack_d = 1'b1;
							addr_d[WORD_BITS-1:0] = byte_in;
						end
						ST_WDATA: begin
							if (!wp_s2_q) begin
								ack_d = 1'b1;
								buf_we = 1'b1;
								mask_d[addr_q[PAGE_OFF_W-1:0]] = 1'b1;
							end
						end
						ST_RDATA: begin
							addr_d = next_addr(addr_q, 1'b0);
						end
						default: begin
						end
					endcase
				end
			end else begin
				cnt_d = 4'h0;
				ack_d = 1'b0;
				unique case (st_q)
					ST_DEV: begin
						if (sh_q[DIR_BIT_POS]) begin
							st_d = ST_RDATA;
						end else begin
							st_d = ST_ADDR_HI;
							mask_d = MASK_RST;
						end
					end
					ST_ADDR_HI: st_d = ST_ADDR_LO;
					ST_ADDR_LO: st_d = ST_WDATA;
					ST_WDATA: begin
						if (ack_q) begin
							addr_d = next_addr(addr_q, 1'b1);
						end else begin
							st_d = ST_WAIT;
						end
					end
					ST_RDATA: begin
						// no-ack: release and wait for start or stop
						if (samp_bit) begin
							st_d = ST_WAIT;
						end
					end
					default: begin
					end
				endcase
			end
		end
		// ack slot, read bits msb first
		drv_d = ack_d ||
			(st_d == ST_RDATA && cnt_d != ACK_SLOT && !msb_first_bit(arr_rdata, cnt_d));
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			st_q <= ST_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			addr_q <= ADDR_RST;
			ack_q <= 1'b0;
			mask_q <= MASK_RST;
			prog_q <= '0;
			drv_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			addr_q <= addr_d;
			ack_q <= ack_d;
			mask_q <= mask_d;
			prog_q <= prog_d;
			drv_q <= drv_d;
			armed_q <= armed_d;
		end
	end

	// Page buffer: holds one page until the stop commits it
	seewp_mem #(
		.AW(PAGE_OFF_W),
		.DW(WORD_BITS)
	) u_page_buf (
		.clk(CLK_SYS),
		.we(buf_we),
		.waddr(addr_q[PAGE_OFF_W-1:0]),
		.wdata(byte_in),
		.raddr(buf_raddr),
		.rdata_q(buf_rdata)
	);

	// Main array; written only during the programming cycle
	seewp_mem #(
		.AW(ADDR_W),
		.DW(WORD_BITS)
	) u_array (
		.clk(CLK_SYS),
		.we(arr_we),
		.waddr({addr_q[ADDR_W-1:PAGE_OFF_W], copy_idx}),
		.wdata(buf_rdata),
		.raddr(addr_q),
		.rdata_q(arr_rdata)
	);

	// open drain: level always low, only the enable moves
	assign SDA_O = 1'b0;
	// enable gated until the link register has seen a fall
	assign SDA_OE = drv_link_q & armed_q;
	// busy for the whole programming cycle
	assign PROG_BUSY = (st_q == ST_PROG);
	// pull-downs live in the pad; open pins arrive here as low
	// relies on the controller's rate for sync margins
endmodule

// ==== include/seewp_pkg.sv ====
// Shared constants and types for the serial memory target read and write paths
package seewp_pkg;
	// Frame layout
	localparam int WORD_BITS = 8;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam int TYPE_CODE_W = 4;
	localparam int STRAP_W = 3;
	localparam int DIR_BIT_POS = 0;
	localparam int STRAP_LSB = 1;
	localparam int TYPE_LSB = 4;
	// Array geometry
	localparam int ADDR_W = 13;
	localparam int ADDR_HI_W = 5;
	localparam int PAGE_OFF_W = 5;
	localparam int PAGE_BYTES = 32;
	localparam int ARRAY_BYTES = 8192;
	// Timing
	localparam longint SYS_CLK_HZ = 125000000;
	localparam longint PROG_TIME_MS = 5;
	// Longest time, so the count rounds down
	localparam int PROG_CYCLES = int'((PROG_TIME_MS * SYS_CLK_HZ) / 1000);
	// Reset values
	localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
	localparam logic [PAGE_BYTES-1:0] MASK_RST = 32'h00000000;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_ADDR_HI,
		ST_ADDR_LO,
		ST_WDATA,
		ST_RDATA,
		ST_WAIT,
		ST_PROG
	} seewp_state_t;
endpackage

// ==== sim/seewp_ctrl_model.sv ====
// Behavioural two-wire bus controller: makes SCL, pulls SDA low
`timescale 1ns/1ps
module seewp_ctrl_model (
	output logic scl,
	output logic pull,
	input wire logic sda
);
	localparam realtime Q = 31.25;
	initial begin
		scl = 1'b1;
		pull = 1'b0;
	end
	// one bit, data moved with SCL low, 125 ns period
	task automatic bitc(input logic lo, output logic s);
		#Q pull = lo;
		#Q scl = 1'b1;
		#Q s = sda;
		#Q scl = 1'b0;
	endtask
	task automatic start();
		#Q pull = 1'b0;
		#Q scl = 1'b1;
		#Q pull = 1'b1;
		#Q scl = 1'b0;
	endtask
	// SCL stays high afterwards, the bus is idle
	task automatic stop();
		#Q pull = 1'b1;
		#Q scl = 1'b1;
		#Q pull = 1'b0;
		#Q;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bitc(~d[i], s);
		bitc(1'b0, ack);
	endtask
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitc(1'b0, s);
			d[i] = s;
		end
		bitc(~nack, s);
	endtask
endmodule

// ==== sim/seewp_target_properties.sv ====
// Port-level checks on the serial memory target
`timescale 1ns/1ps
module seewp_target_properties #(
	parameter int PROG_CYCLES_P = 600
) (
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	input wire logic SCL,
	input wire logic SDA_I,
	input wire logic SDA_O,
	input wire logic SDA_OE,
	input wire logic WRITE_INHIBIT,
	input wire logic PROG_BUSY
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);
	int busy_cnt_q;
	int busy_cnt_d;
	// Length of the current programming cycle
	always_comb busy_cnt_d = PROG_BUSY ? busy_cnt_q + 1 : 0;
	always_ff @(posedge CLK_SYS) busy_cnt_q <= SYS_RST ? 0 : busy_cnt_d;
	a_open_drain: assert property (SDA_O == 1'b0)
		else $error("SDA_O driven high");
	a_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL)
		else $error("SDA_OE moved with SCL high");
	a_oe_stable_high: assert property (SCL && $past(SCL) |-> $stable(SDA_OE))
		else $error("SDA_OE unstable in SCL high phase");
	a_busy_no_ack: assert property (PROG_BUSY |-> !SDA_OE)
		else $error("SDA pulled while programming");
	a_busy_bound: assert property (busy_cnt_q <= PROG_CYCLES_P)
		else $error("programming cycle too long");
	a_busy_after_stop: assert property ($rose(PROG_BUSY) |-> SCL && SDA_I)
		else $error("programming began without stop");
	a_busy_holds: assert property ($rose(PROG_BUSY) |-> PROG_BUSY [*8])
		else $error("programming cycle cut short");
	a_inhibit_no_prog: assert property (WRITE_INHIBIT && $past(WRITE_INHIBIT, 4) && !PROG_BUSY
		|=> !PROG_BUSY)
		else $error("programming with inhibit high");
	c_prog: cover property ($rose(PROG_BUSY));
	c_ack: cover property ($rose(SDA_OE));
	c_inhibit: cover property (WRITE_INHIBIT && $fell(SDA_OE));
endmodule

bind seewp_target seewp_target_properties #(.PROG_CYCLES_P(PROG_CYCLES_P)) u_props (
	.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .SCL(SCL), .SDA_I(SDA_I), .SDA_O(SDA_O),
	.SDA_OE(SDA_OE), .WRITE_INHIBIT(WRITE_INHIBIT), .PROG_BUSY(PROG_BUSY));

// ==== sim/seewp_target_tb.sv ====
// Self-checking bench for the serial memory target
`timescale 1ns/1ps
module seewp_target_tb;
	localparam logic [3:0] TC = 4'h5;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic inh = 1'b0;
	logic [2:0] strap = 3'h6;
	logic oe, busy, scl, pull, so;
	logic [7:0] d0, d1;
	wire sda = !(oe || pull);
	int num_errors = 0;
	int n_compared = 0;
	seewp_ctrl_model ctl (.scl(scl), .pull(pull), .sda(sda));
	seewp_target #(.TYPE_CODE(TC), .PROG_CYCLES_P(600)) uut (
		.CLK_SYS(clk), .SYS_RST(rst), .SCL(scl), .SDA_I(sda), .SDA_O(so),
		.SDA_OE(oe), .WRITE_INHIBIT(inh), .SELECT_STRAP_BIT0(strap[0]),
		.SELECT_STRAP_BIT1(strap[1]), .SELECT_STRAP_BIT2(strap[2]), .PROG_BUSY(busy));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic ack(input logic k, input logic exp);
		check({7'h0, k}, {7'h0, exp});
	endtask
	task automatic end_of_test();
		if (num_errors == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic dev(input logic [3:0] t, input logic [2:0] s, input logic r, output logic k);
		ctl.start();
		ctl.wbyte({t, s, r}, k);
	endtask
	task automatic setaddr(input logic [15:0] a);
		logic k;
		dev(TC, strap, 1'b0, k);
		ack(k, 1'b0); // address word
		ctl.wbyte(a[15:8], k);
		ack(k, 1'b0); // high byte first
		ctl.wbyte(a[7:0], k);
		ack(k, 1'b0); // low byte
	endtask
	task automatic wr(input logic [15:0] a, input int n, input logic [7:0] b, input logic na);
		logic k;
		setaddr(a);
		for (int i = 0; i < n; i++) begin
			ctl.wbyte(b + 8'(i), k);
			ack(k, na); // data answer
		end
		ctl.stop();
	endtask
	task automatic rd2(input logic [15:0] a);
		logic k;
		setaddr(a);
		dev(TC, strap, 1'b1, k);
		ack(k, 1'b0); // read entered
		ctl.rbyte(1'b0, d0);
		ctl.rbyte(1'b1, d1);
		ctl.stop();
	endtask
	task automatic wait_prog();
		int n = 0;
		logic k;
		repeat (8) @(posedge clk);
		ack(busy, 1'b1); // programming started
		dev(TC, strap, 1'b0, k);
		ack(k, 1'b1); // poll while busy
		while (busy !== 1'b0) begin
			@(posedge clk);
			n++;
			if (n > 1000) begin
				ack(busy, 1'b0); // cycle ends in time
				end_of_test();
			end
		end
		dev(TC, strap, 1'b0, k);
		ack(k, 1'b0); // poll when done
		ctl.stop();
	endtask
	task automatic t_select();
		logic k;
		dev(TC, strap ^ 3'h1, 1'b0, k);
		ack(k, 1'b1); // strap mismatch
		dev(4'h6, strap, 1'b0, k);
		ack(k, 1'b1); // type mismatch
		ctl.stop();
		@(posedge clk);
		strap <= 3'h0;
		repeat (4) @(posedge clk);
		dev(TC, 3'h0, 1'b0, k);
		ack(k, 1'b0); // straps low
		ctl.stop();
		@(posedge clk);
		strap <= 3'h6;
		repeat (4) @(posedge clk);
	endtask
	task automatic t_byte();
		wr(16'he123, 1, 8'ha5, 1'b0);
		wait_prog();
		rd2(16'h0123);
		check(d0, 8'ha5); // byte written
	endtask
	task automatic t_page();
		wr(16'h005e, 34, 8'h00, 1'b0);
		wait_prog();
		rd2(16'h005e);
		check(d0, 8'h20); // wrap overwrite
		check(d1, 8'h21); // next address
		rd2(16'h0040);
		check(d0, 8'h02); // page offset
	endtask
	task automatic t_inhibit();
		@(posedge clk);
		inh <= 1'b1;
		repeat (4) @(posedge clk);
		wr(16'h0040, 1, 8'h77, 1'b1);
		repeat (8) @(posedge clk);
		ack(busy, 1'b0); // no programming
		rd2(16'h0040);
		check(d0, 8'h02); // read with inhibit
		@(posedge clk);
		inh <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic t_noack();
		logic k;
		setaddr(16'h0041);
		dev(TC, strap, 1'b1, k);
		ctl.rbyte(1'b1, d0);
		check(d0, 8'h03); // msb first
		ctl.rbyte(1'b1, d1);
		check(d1, 8'hff); // line left released
		ctl.stop();
	endtask
	initial forever #4 clk = ~clk;
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_select();
		t_byte();
		t_page();
		t_inhibit();
		t_noack();
		end_of_test();
	end
endmodule
